//--- phy_statistics_counters.sv
// phy statistics counter bank behind the advanced address and read-data ports
// Behaviour
// - 48-bit counter of bad-crc frames
// - crc mid register returns bits 31:16
// - crc low register returns bits 15:0
// - high word read clears whole 48-bit counter
// - count error rises while data valid high
// - count error rises while data valid low
// - error and valid recovered from control pin
// - tx frame counter, high returns 47:32
// - tx mid register returns bits 31:16
// - tx low register returns bits 15:0
// - tx high read clears whole counter
// - crc high returns 47:32, read clears
// - counter registers ignore all writes
`timescale 1ns/10ps
module phy_statistics_counters #(
	parameter int unsigned WIDE = stat_cnt_pkg::WIDE_W,
	parameter int unsigned NARROW = stat_cnt_pkg::REG_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire stat_cnt_pkg::adv_addr_t i_adv_addr,
	input wire stat_cnt_pkg::adv_read_t i_adv_read,
	input wire stat_cnt_pkg::rx_ctrl_t i_rx_control_pin,
	input wire logic i_crc_bad_frame,
	input wire logic i_tx_frame_done,
	output logic [stat_cnt_pkg::REG_W-1:0] o_adv_rdata,
	output logic o_adv_rvalid,
	output logic o_adv_selected
);
	import stat_cnt_pkg::*;

	port_state_t state_q;
	logic [IDX_W-1:0] index_q;
	logic rd_go;
	logic rx_dv;
	logic rx_er;
	logic crc_snap;
	logic crc_clear;
	logic tx_snap;
	logic tx_clear;
	logic rxd_clear;
	logic rxi_clear;
	logic [WIDE-1:0] crc_live;
	logic [WIDE-1:0] crc_held;
	logic [WIDE-1:0] tx_live;
	logic [WIDE-1:0] tx_held;
	logic [NARROW-1:0] rxd_count;
	logic [NARROW-1:0] rxi_count;
	logic [REG_W-1:0] rdata_d;

	// control pin: first phase is data valid, second is valid xor error
	assign rx_dv = i_rx_control_pin.rise;
	assign rx_er = i_rx_control_pin.rise ^ i_rx_control_pin.fall;

	// index is only taken with the read flag set
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			index_q <= '0;
		end else if (i_adv_addr.wr && i_adv_addr.read_flag) begin
			index_q <= i_adv_addr.index;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_q <= PHASE_IDLE;
		end else begin
			case (state_q)
				PHASE_IDLE: begin
					if (i_adv_addr.wr && i_adv_addr.read_flag) begin
						state_q <= PHASE_SELECTED;
					end
				end
				PHASE_SELECTED: begin
					state_q <= PHASE_SELECTED;
				end
				default: begin
					state_q <= PHASE_IDLE;
				end
			endcase
		end
	end

	assign o_adv_selected = (state_q == PHASE_SELECTED);
	assign rd_go = i_adv_read.rd && (state_q == PHASE_SELECTED);

	assign crc_snap = rd_go && (index_q == IDX_CRC_LOW);
	assign crc_clear = rd_go && (index_q == IDX_CRC_HIGH);
	assign tx_snap = rd_go && (index_q == IDX_TX_LOW);
	assign tx_clear = rd_go && (index_q == IDX_TX_HIGH);
	assign rxd_clear = rd_go && (index_q == IDX_RXERR_DATA);
	assign rxi_clear = rd_go && (index_q == IDX_RXERR_IDLE);

	wide_counter #(.W(WIDE)) u_crc_count (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_event(i_crc_bad_frame),
		.i_snap(crc_snap),
		.i_clear(crc_clear),
		.o_live(crc_live),
		.o_snap(crc_held)
	);

	wide_counter #(.W(WIDE)) u_tx_count (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_event(i_tx_frame_done),
		.i_snap(tx_snap),
		.i_clear(tx_clear),
		.o_live(tx_live),
		.o_snap(tx_held)
	);

	rise_counter #(.W(NARROW)) u_rx_err_data (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_level(rx_er),
		.i_qual(rx_dv),
		.i_clear(rxd_clear),
		.o_count(rxd_count)
	);

	rise_counter #(.W(NARROW)) u_rx_err_idle (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_level(rx_er),
		.i_qual(!rx_dv),
		.i_clear(rxi_clear),
		.o_count(rxi_count)
	);

	// read mux: low words come live, mid and high from the snapshot
	always_comb begin
		rdata_d = REG_RESET;
		case (index_q)
			IDX_CRC_LOW: rdata_d = crc_live[LOW_LSB +: REG_W];
			IDX_CRC_MID: rdata_d = crc_held[MID_LSB +: REG_W];
			IDX_CRC_HIGH: rdata_d = crc_held[HIGH_LSB +: REG_W];
			IDX_RXERR_DATA: rdata_d = rxd_count[REG_W-1:0];
			IDX_RXERR_IDLE: rdata_d = rxi_count[REG_W-1:0];
			IDX_TX_LOW: rdata_d = tx_live[LOW_LSB +: REG_W];
			IDX_TX_MID: rdata_d = tx_held[MID_LSB +: REG_W];
			IDX_TX_HIGH: rdata_d = tx_held[HIGH_LSB +: REG_W];
			default: rdata_d = REG_RESET;
		endcase
	end

	// no write path exists into any counter
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_adv_rdata <= REG_RESET;
		end else if (rd_go) begin
			o_adv_rdata <= rdata_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_adv_rvalid <= 1'b0;
		end else begin
			o_adv_rvalid <= rd_go;
		end
	end
endmodule

//--- stat_cnt_pkg.sv
// package of constants and types for the phy statistics counter bank
package stat_cnt_pkg;
	localparam int unsigned REG_W = 16;
	localparam int unsigned WIDE_W = 48;
	localparam int unsigned IDX_W = 5;
	localparam logic [IDX_W-1:0] IDX_CRC_HIGH = 5'h05;
	localparam logic [IDX_W-1:0] IDX_CRC_MID = 5'h06;
	localparam logic [IDX_W-1:0] IDX_CRC_LOW = 5'h07;
	localparam logic [IDX_W-1:0] IDX_RXERR_DATA = 5'h08;
	localparam logic [IDX_W-1:0] IDX_RXERR_IDLE = 5'h09;
	localparam logic [IDX_W-1:0] IDX_TX_HIGH = 5'h0a;
	localparam logic [IDX_W-1:0] IDX_TX_MID = 5'h0b;
	localparam logic [IDX_W-1:0] IDX_TX_LOW = 5'h0c;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [WIDE_W-1:0] WIDE_RESET = 48'h000000000000;
	localparam int unsigned LOW_LSB = 0;
	localparam int unsigned MID_LSB = 16;
	localparam int unsigned HIGH_LSB = 32;

	// advanced address port write: read flag plus register index
	typedef struct packed {
		logic wr;
		logic read_flag;
		logic [IDX_W-1:0] index;
	} adv_addr_t;

	// advanced read-data port strobe
	typedef struct packed {
		logic rd;
	} adv_read_t;

	// receive control pin sampled on rising and falling edge phases
	typedef struct packed {
		logic rise;
		logic fall;
	} rx_ctrl_t;

	typedef enum logic [1:0] {
		PHASE_IDLE,
		PHASE_SELECTED
	} port_state_t;
endpackage

//--- wide_counter.sv
// 48-bit saturating-free event counter with coherent split read and clear on high read
`timescale 1ns/10ps
module wide_counter #(
	parameter int unsigned W = 48
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_event,
	input wire logic i_snap,
	input wire logic i_clear,
	output logic [W-1:0] o_live,
	output logic [W-1:0] o_snap
);
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_live <= '0;
		end else if (i_clear) begin
			o_live <= {{(W-1){1'b0}}, i_event};
		end else if (i_event) begin
			o_live <= o_live + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_snap <= '0;
		end else if (i_snap) begin
			o_snap <= o_live;
		end
	end
endmodule

//--- rise_counter.sv
// 16-bit counter of rising edges of a qualified error level, clear on read
`timescale 1ns/10ps
module rise_counter #(
	parameter int unsigned W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_level,
	input wire logic i_qual,
	input wire logic i_clear,
	output logic [W-1:0] o_count
);
	logic level_q;
	logic hit;

	assign hit = i_level && !level_q && i_qual;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			level_q <= 1'b0;
		end else begin
			level_q <= i_level;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_count <= '0;
		end else if (i_clear) begin
			o_count <= {{(W-1){1'b0}}, hit};
		end else if (hit) begin
			o_count <= o_count + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

//--- phy_statistics_counters_asserts.sv
// checker of the counter bank port behaviour
`timescale 1ns/10ps
module stat_asserts #(
	parameter int unsigned WIDE = 48,
	parameter int unsigned NARROW = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire stat_cnt_pkg::adv_addr_t i_adv_addr,
	input wire stat_cnt_pkg::adv_read_t i_adv_read,
	input wire stat_cnt_pkg::rx_ctrl_t i_rx_control_pin,
	input wire logic i_crc_bad_frame,
	input wire logic i_tx_frame_done,
	input wire logic [stat_cnt_pkg::REG_W-1:0] o_adv_rdata,
	input wire logic o_adv_rvalid,
	input wire logic o_adv_selected
);
	import stat_cnt_pkg::*;
	logic [IDX_W-1:0] idx_q;
	wire logic take = i_adv_addr.wr && i_adv_addr.read_flag;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			idx_q <= '0;
		end else if (take) begin
			idx_q <= i_adv_addr.index;
		end
	end
	property p_rv; o_adv_rvalid == $past(i_adv_read.rd && o_adv_selected); endproperty
	a_rv: assert property (p_rv) else $error("rvalid");
	property p_hold; !o_adv_rvalid |-> $stable(o_adv_rdata); endproperty
	a_hold: assert property (p_hold) else $error("rdata");
	property p_keep; o_adv_selected |=> o_adv_selected; endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_set; take |=> o_adv_selected; endproperty
	a_set: assert property (p_set) else $error("set");
	property p_ign; i_adv_addr.wr && !i_adv_addr.read_flag && !o_adv_selected |=> !o_adv_selected; endproperty
	a_ign: assert property (p_ign) else $error("ign");
	property p_rose; $rose(o_adv_selected) |-> $past(take); endproperty
	a_rose: assert property (p_rose) else $error("rose");
	property p_unm; o_adv_rvalid && $past(idx_q) > IDX_TX_LOW |-> o_adv_rdata == REG_RESET; endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_rst;
		disable iff (1'b0) !i_rst_b |=> o_adv_rdata == REG_RESET && !o_adv_rvalid && !o_adv_selected;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	c_data: cover property (o_adv_rvalid && o_adv_rdata != REG_RESET);
	c_sel: cover property ($rose(o_adv_selected));
	c_high: cover property (i_adv_read.rd && o_adv_selected && idx_q == IDX_CRC_HIGH);
endmodule
bind phy_statistics_counters stat_asserts #(.WIDE(WIDE), .NARROW(NARROW)) i_stat_asserts (.*);

//--- mac_side_model.sv
// far side: encodes valid and error onto the control pin
`timescale 1ns/10ps
module mac_side_model (
	input wire logic i_dv,
	input wire logic i_er,
	output stat_cnt_pkg::rx_ctrl_t o_pin
);
	import stat_cnt_pkg::*;
	assign o_pin = '{rise: i_dv, fall: i_dv ^ i_er};
endmodule

//--- phy_statistics_counters_test.sv
// self-checking bench of the counter bank
`timescale 1ns/10ps
module phy_statistics_counters_test;
	import stat_cnt_pkg::*;
	logic i_clk, i_rst_b, crc, tx, dv, er, o_adv_rvalid, o_adv_selected;
	logic [REG_W-1:0] o_adv_rdata;
	adv_addr_t a;
	adv_read_t r;
	rx_ctrl_t pin;
	int n_mismatch, tests_run;
	mac_side_model i_mac_side_model (.i_dv(dv), .i_er(er), .o_pin(pin));
	phy_statistics_counters i_phy_statistics_counters (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_adv_addr(a),
		.i_adv_read(r), .i_rx_control_pin(pin), .i_crc_bad_frame(crc), .i_tx_frame_done(tx),
		.o_adv_rdata(o_adv_rdata), .o_adv_rvalid(o_adv_rvalid), .o_adv_selected(o_adv_selected));
	initial begin
		i_clk = 0;
		forever #2 i_clk = ~i_clk;
	end
	task close_out;
		if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task cmp(input logic [16:0] g, input logic [16:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task sel(input logic [IDX_W-1:0] i, input logic f);
		@(negedge i_clk) a = '{1'b1, f, i};
		@(negedge i_clk) a.wr = 0;
	endtask
	task rd(input logic [16:0] e);
		@(negedge i_clk) r.rd = 1;
		@(negedge i_clk) r.rd = 0;
		cmp({o_adv_rvalid, o_adv_rdata}, e);
	endtask
	task rr(input logic [IDX_W-1:0] i, input logic [REG_W-1:0] e);
		sel(i, 1);
		rd({1'b1, e});
	endtask
	task ev(input logic c, input logic t, input logic d, input logic e);
		@(negedge i_clk) {crc, tx, dv, er} = {c, t, d, e};
		@(negedge i_clk) {crc, tx, er} = 3'h0;
	endtask
	task t_refuse;
		sel(IDX_CRC_LOW, 0);
		cmp({16'h0000, o_adv_selected}, 17'h00000);
		rd(17'h00000);
		rr(5'h0d, 16'h0000);
		cmp({16'h0000, o_adv_selected}, 17'h00001);
	endtask
	task t_rerst;
		ev(1, 1, 0, 0);
		@(negedge i_clk) i_rst_b = 0;
		repeat (2) @(negedge i_clk);
		cmp({o_adv_rvalid, o_adv_rdata}, 17'h00000);
		cmp({16'h0000, o_adv_selected}, 17'h00000);
		i_rst_b = 1;
		rr(IDX_CRC_LOW, 16'h0000);
		rr(IDX_TX_LOW, 16'h0000);
	endtask
	task t_reset;
		for (int i = 5; i <= 12; i++) rr(i[IDX_W-1:0], REG_RESET);
	endtask
	task t_crc;
		repeat (3) ev(1, 0, 0, 0);
		rr(IDX_CRC_LOW, 16'h0003);
		ev(1, 0, 0, 0);
		rr(IDX_CRC_MID, 16'h0000);
		rr(IDX_CRC_HIGH, 16'h0000);
		rr(IDX_CRC_LOW, 16'h0000);
	endtask
	task t_tx;
		repeat (2) ev(0, 1, 0, 0);
		rr(IDX_TX_LOW, 16'h0002);
		rr(IDX_TX_MID, 16'h0000);
		rr(IDX_TX_HIGH, 16'h0000);
		rr(IDX_TX_LOW, 16'h0000);
	endtask
	task t_rx;
		repeat (2) ev(0, 0, 1, 1);
		ev(0, 0, 0, 1);
		rr(IDX_RXERR_DATA, 16'h0002);
		rr(IDX_RXERR_DATA, 16'h0000);
		rr(IDX_RXERR_IDLE, 16'h0001);
	endtask
	initial begin
		#2000;
		n_mismatch++;
		close_out;
	end
	initial begin
		{i_rst_b, crc, tx, dv, er} = 5'h00;
		a = '0;
		r = '0;
		repeat (5) @(negedge i_clk);
		i_rst_b = 1;
		t_refuse;
		t_reset;
		t_crc;
		t_tx;
		t_rx;
		t_rerst;
		close_out;
	end
endmodule
